// file: logic/rstint_defs.svh
// constants of the reset and interrupt control block
`ifndef RSTINT_DEFS_SVH
`define RSTINT_DEFS_SVH
`define RI_ADDR_W       8
`define RI_IDX_HI       7
`define RI_IDX_LO       2
`define RI_IDX_CTRL     6'h08
`define RI_IDX_STAT     6'h09
`define RI_IDX_KWEN     6'h0a
`define RI_CTRL_EXT_EN  7
`define RI_CTRL_KW_EN   4
`define RI_CTRL_EDGE    3
`define RI_STAT_EXT_F   7
`define RI_STAT_KW_F    4
`define RI_STAT_EXT_CLR 3
`define RI_STAT_KW_CLR  0
`define RI_KEYS         4
`define RI_PINS         6
`define RI_PIN_EXT      0
`define RI_PIN_RST      1
`define RI_PIN_KEY      2
`define RI_PINS_IDLE    6'h3f
`define RI_RESP_OKAY    2'h0
`define RI_RESP_SLVERR  2'h2
`define RI_POD_W        15
`define RI_POD_MIN      15'h3f00
`define RI_POD_MAX      15'h4000
`define RI_VEC_W        13
`define RI_VEC_RESET    13'h1ffe
`define RI_VEC_SWI      13'h1ffc
`define RI_VEC_EXT      13'h1ffa
`define RI_VEC_KEY      13'h1ff8
`define RI_VEC_PWC      13'h1ff6
`define RI_VEC_EVT      13'h1ff4
`define RI_VEC_SPI      13'h1ff2
`define RI_VEC_TB       13'h1ff0
`define RI_NSRC         6
`define RI_SRC_EXT      0
`define RI_SRC_KEY      1
`define RI_SRC_PWC      2
`define RI_SRC_EVT      3
`define RI_SRC_SPI      4
`define RI_SRC_TB       5
`endif

// file: logic/rstint_pkg.sv
// types of the reset and interrupt control block
`include "rstint_defs.svh"
package rstint_pkg;
    typedef enum logic [1:0] {SEL_CTRL, SEL_STAT, SEL_KWEN, SEL_NONE} rstint_sel_t;

    typedef struct packed {
        logic                   rst;
        logic                   ext_low_prev;
        logic                   wd_prev;
        logic                   op_mode;
        logic                   ext_en;
        logic                   kw_en;
        logic                   edge_only;
        logic                   ext_flag;
        logic [`RI_KEYS-1:0]    kw_latch;
        logic [`RI_KEYS-1:0]    kw_inen;
        logic [`RI_PINS-1:0]    pin_prev;
        logic                   ext_line;
        logic                   int_take;
        logic [`RI_VEC_W-1:0]   vector;
        logic                   vec_valid;
        logic                   mask_set;
        logic                   awrdy;
        logic                   wrdy;
        logic                   aw_have;
        logic                   w_have;
        logic [`RI_ADDR_W-1:0]  awaddr;
        logic [7:0]             wdata;
        logic                   wstrb0;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arrdy;
        logic                   rvalid;
        logic [7:0]             rdata;
        logic [1:0]             rresp;
    } rstint_st_t;

    typedef struct packed {
        logic [`RI_PINS-1:0] s1;
        logic [`RI_PINS-1:0] s2;
        logic [`RI_PINS-1:0] s3;
        logic [`RI_PINS-1:0] clean;
    } rstint_sync_st_t;

    typedef struct packed {
        logic [`RI_POD_W-1:0] cnt;
        logic                 busy;
    } rstint_pod_st_t;
endpackage

// file: logic/rstint_pin_if.sv
// raw and cleaned pin levels between top and synchroniser
`include "rstint_defs.svh"
interface rstint_pin_if;
    logic [`RI_PINS-1:0] raw;
    logic [`RI_PINS-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// file: logic/rstint_sync.sv
// three-stage pin synchroniser with agreement filter
`include "rstint_defs.svh"
module rstint_sync import rstint_pkg::*; (
    // clock and reset
    input  wire logic   aclk,
    input  wire logic   aresetn,
    // pins
    rstint_pin_if.sync  pins
);
    rstint_sync_st_t st, nx;

    always_comb begin
        nx = st;
        nx.s1 = pins.raw;
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        for (int i = 0; i < `RI_PINS; i++) begin
            // a bit counts only once stages two and three agree
            if (st.s2[i] == st.s3[i]) begin
                nx.clean[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '{default: `RI_PINS_IDLE};
        end else begin
            st <= nx;
        end
    end

    assign pins.clean = st.clean;
endmodule // rstint_sync

// file: logic/rstint_pod.sv
// power-on oscillator delay counter
`include "rstint_defs.svh"
module rstint_pod import rstint_pkg::*; #(
    parameter logic [`RI_POD_W-1:0] POD_CYCLES = `RI_POD_MAX
) (
    // clock and power-up reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // delay state
    output logic      busy
);
    rstint_pod_st_t st, nx;

    always_comb begin
        nx = st;
        if (st.cnt != POD_CYCLES) begin
            nx.cnt = st.cnt + `RI_POD_W'(1);
        end
        nx.busy = (nx.cnt != POD_CYCLES);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '{cnt: '0, busy: 1'b1};
        end else begin
            st <= nx;
        end
    end

    assign busy = st.busy;
endmodule // rstint_pod

// file: logic/rstint_top.sv
// reset sequencing and interrupt control with an AXI4-Lite register port
//
// Register access over AXI4-Lite was decided locally.
`include "rstint_defs.svh"
module rstint_top import rstint_pkg::*; #(
    parameter logic [`RI_POD_W-1:0] POD_CYCLES = `RI_POD_MAX
) (
    // clock and power-up reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // reset sources and mode strap
    input  wire logic                  ext_reset_pin_n,
    input  wire logic                  watchdog_timeout_reset,
    input  wire logic                  watchdog_enable,
    input  wire logic                  mode_strap,
    output logic                       sys_reset,
    output logic                       op_mode,
    // interrupt pins and peripheral requests
    input  wire logic                  ext_int_pin_n,
    input  wire logic [`RI_KEYS-1:0]   key_wake_pins_n,
    input  wire logic                  pulse_width_int,
    input  wire logic                  event_count_int,
    input  wire logic                  serial_periph_int,
    input  wire logic                  timebase_int,
    // cpu core handshake
    input  wire logic                  cpu_imask,
    input  wire logic                  cpu_insn_done,
    input  wire logic                  cpu_stacked,
    input  wire logic                  soft_trap_instr,
    output logic                       int_take,
    output logic [`RI_VEC_W-1:0]       vector_addr,
    output logic                       vector_valid,
    output logic                       cpu_mask_set,
    output logic                       ext_int_line,
    // axi4-lite write
    input  wire logic [`RI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read
    input  wire logic [`RI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);
    localparam rstint_st_t RST_ST = '{rst: 1'b1, ext_line: 1'b1, pin_prev: `RI_PINS_IDLE,
                                      vector: `RI_VEC_RESET, mask_set: 1'b1, default: '0};

    rstint_st_t             st, nx;
    rstint_pin_if           pins ();
    logic                   pod_busy;
    logic                   ext_low;
    logic                   wd_act;
    logic                   ext_end;
    logic                   wd_end;
    logic                   ext_fall;
    logic [`RI_KEYS-1:0]    key_fall;
    logic                   wr_fire;
    rstint_sel_t            wr_sel;
    logic                   wr_ext_clr;
    logic                   wr_kw_clr;
    logic [`RI_NSRC-1:0]    req;

    function automatic rstint_sel_t decode(input logic [`RI_ADDR_W-1:0] a);
        case (a[`RI_IDX_HI:`RI_IDX_LO])
            `RI_IDX_CTRL: decode = SEL_CTRL;
            `RI_IDX_STAT: decode = SEL_STAT;
            `RI_IDX_KWEN: decode = SEL_KWEN;
            default:      decode = SEL_NONE;
        endcase
    endfunction

    // highest vector wins among pending sources
    function automatic logic [`RI_VEC_W-1:0] pick(input logic [`RI_NSRC-1:0] r);
        if (r[`RI_SRC_EXT]) begin
            pick = `RI_VEC_EXT;
        end else if (r[`RI_SRC_KEY]) begin
            pick = `RI_VEC_KEY;
        end else if (r[`RI_SRC_PWC]) begin
            pick = `RI_VEC_PWC;
        end else if (r[`RI_SRC_EVT]) begin
            pick = `RI_VEC_EVT;
        end else if (r[`RI_SRC_SPI]) begin
            pick = `RI_VEC_SPI;
        end else begin
            pick = `RI_VEC_TB;
        end
    endfunction

    assign pins.raw = {key_wake_pins_n, ext_reset_pin_n, ext_int_pin_n};

    rstint_sync u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pins    (pins)
    );

    rstint_pod #(.POD_CYCLES(POD_CYCLES)) u_pod (
        .aclk    (aclk),
        .aresetn (aresetn),
        .busy    (pod_busy)
    );

    assign ext_low    = !pins.clean[`RI_PIN_RST];
    assign wd_act     = watchdog_timeout_reset && watchdog_enable;
    assign ext_end    = st.ext_low_prev && !ext_low;
    assign wd_end     = st.wd_prev && !wd_act;
    assign ext_fall   = st.pin_prev[`RI_PIN_EXT] && !pins.clean[`RI_PIN_EXT];
    assign key_fall   = st.pin_prev[`RI_PIN_KEY +: `RI_KEYS] & ~pins.clean[`RI_PIN_KEY +: `RI_KEYS];
    assign wr_fire    = st.aw_have && st.w_have && !st.bvalid;
    assign wr_sel     = decode(st.awaddr);
    assign wr_ext_clr = wr_fire && st.wstrb0 && wr_sel == SEL_STAT && st.wdata[`RI_STAT_EXT_CLR];
    assign wr_kw_clr  = wr_fire && st.wstrb0 && wr_sel == SEL_STAT && st.wdata[`RI_STAT_KW_CLR];
    assign req[`RI_SRC_EXT] = st.ext_flag && st.ext_en;
    assign req[`RI_SRC_KEY] = (|st.kw_latch) && st.kw_en;
    assign req[`RI_SRC_PWC] = pulse_width_int;
    assign req[`RI_SRC_EVT] = event_count_int;
    assign req[`RI_SRC_SPI] = serial_periph_int;
    assign req[`RI_SRC_TB]  = timebase_int;

    always_comb begin
        nx = st;
        nx.int_take  = 1'b0;
        nx.vec_valid = 1'b0;
        // plain registered or of sources: pod end alone never releases early
        nx.rst = pod_busy || ext_low || wd_act;
        nx.ext_low_prev = ext_low;
        nx.wd_prev = wd_act;
        if (ext_end || wd_end) begin
            nx.op_mode = mode_strap;
        end
        nx.pin_prev = pins.clean;
        nx.ext_line = pins.clean[`RI_PIN_EXT];

        // write channel
        if (st.bvalid && s_axi_bready) begin
            nx.bvalid = 1'b0;
        end
        if (st.awrdy && s_axi_awvalid) begin
            nx.aw_have = 1'b1;
            nx.awaddr  = s_axi_awaddr;
        end
        if (st.wrdy && s_axi_wvalid) begin
            nx.w_have = 1'b1;
            nx.wdata  = s_axi_wdata[7:0];
            nx.wstrb0 = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            nx.aw_have = 1'b0;
            nx.w_have  = 1'b0;
            nx.bvalid  = 1'b1;
            nx.bresp   = (wr_sel == SEL_NONE) ? `RI_RESP_SLVERR : `RI_RESP_OKAY;
            if (st.wstrb0) begin
                case (wr_sel)
                    SEL_CTRL: begin
                        // only the three control bits store, others ignore writes
                        nx.ext_en    = st.wdata[`RI_CTRL_EXT_EN];
                        nx.kw_en     = st.wdata[`RI_CTRL_KW_EN];
                        nx.edge_only = st.wdata[`RI_CTRL_EDGE];
                    end
                    SEL_KWEN: begin
                        nx.kw_inen = st.wdata[`RI_KEYS-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
        nx.awrdy = !nx.aw_have && !nx.bvalid;
        nx.wrdy  = !nx.w_have && !nx.bvalid;

        // read channel
        if (st.rvalid && s_axi_rready) begin
            nx.rvalid = 1'b0;
        end
        if (st.arrdy && s_axi_arvalid) begin
            nx.rvalid = 1'b1;
            nx.rresp  = `RI_RESP_OKAY;
            nx.rdata  = 8'h00;
            case (decode(s_axi_araddr))
                SEL_CTRL: begin
                    nx.rdata[`RI_CTRL_EXT_EN] = st.ext_en;
                    nx.rdata[`RI_CTRL_KW_EN]  = st.kw_en;
                    nx.rdata[`RI_CTRL_EDGE]   = st.edge_only;
                end
                SEL_STAT: begin
                    // clear bits are write-only and read zero
                    nx.rdata[`RI_STAT_EXT_F] = st.ext_flag;
                    nx.rdata[`RI_STAT_KW_F]  = |st.kw_latch;
                end
                SEL_KWEN: begin
                    nx.rdata[`RI_KEYS-1:0] = st.kw_inen;
                end
                default: begin
                    nx.rresp = `RI_RESP_SLVERR;
                end
            endcase
        end
        nx.arrdy = !nx.rvalid;

        // flags: set wins over a clear in the same cycle
        if (wr_ext_clr) begin
            nx.ext_flag = 1'b0;
        end
        if (ext_fall || (!st.edge_only && !pins.clean[`RI_PIN_EXT])) begin
            nx.ext_flag = 1'b1;
        end
        for (int i = 0; i < `RI_KEYS; i++) begin
            if (wr_kw_clr) begin
                nx.kw_latch[i] = 1'b0;
            end
            if (key_fall[i] && st.kw_inen[i]) begin
                nx.kw_latch[i] = 1'b1;
            end
        end

        // taken only at an instruction boundary, never mid-instruction
        if (cpu_insn_done && (|req) && !cpu_imask) begin
            nx.int_take = 1'b1;
        end
        // vector chosen after stacking; trap needs no mask check
        if (cpu_stacked && (|req)) begin
            nx.vector    = pick(req);
            nx.vec_valid = 1'b1;
        end else if (soft_trap_instr) begin
            nx.vector    = `RI_VEC_SWI;
            nx.vec_valid = 1'b1;
        end
        // return from trap restores cpu state itself; nothing is held here for it
        nx.mask_set = nx.int_take;

        if (st.rst) begin
            nx.ext_en    = 1'b0;
            nx.kw_en     = 1'b0;
            nx.edge_only = 1'b0;
            nx.ext_flag  = 1'b0;
            nx.kw_latch  = '0;
            nx.kw_inen   = '0;
            nx.int_take  = 1'b0;
            nx.vec_valid = 1'b0;
            nx.vector    = `RI_VEC_RESET;
            nx.mask_set  = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= RST_ST;
        end else begin
            st <= nx;
        end
    end

    assign sys_reset     = st.rst;
    assign op_mode       = st.op_mode;
    assign int_take      = st.int_take;
    assign vector_addr   = st.vector;
    assign vector_valid  = st.vec_valid;
    assign cpu_mask_set  = st.mask_set;
    assign ext_int_line  = st.ext_line;
    assign s_axi_awready = st.awrdy;
    assign s_axi_wready  = st.wrdy;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_arready = st.arrdy;
    assign s_axi_rdata   = {24'h000000, st.rdata};
    assign s_axi_rresp   = st.rresp;
    assign s_axi_rvalid  = st.rvalid;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence ext_served_s;
        cpu_stacked && req[`RI_SRC_EXT] && !st.rst;
    endsequence
    sequence ext_vector_s;
        vector_addr == `RI_VEC_EXT && vector_valid;
    endsequence

    pin_reset_a: assert property (ext_low |=> sys_reset)
        else $error("reset pin low without system reset");
    pod_hold_a: assert property (pod_busy |=> sys_reset)
        else $error("reset released during power-on delay");
    wd_gate_a: assert property (!pod_busy && !ext_low && !wd_act |=> !sys_reset)
        else $error("system reset without an active source");
    mode_stable_a: assert property (!ext_end && !wd_end |=> $stable(op_mode))
        else $error("mode changed outside external or watchdog reset end");
    ext_set_a: assert property (ext_fall && !st.rst |=> st.ext_flag)
        else $error("falling edge lost on external flag");
    ext_clear_a: assert property (wr_ext_clr && !ext_fall && st.edge_only && !st.rst |=> !st.ext_flag)
        else $error("external flag not cleared by write");
    key_set_a: assert property ((|(key_fall & st.kw_inen)) && !st.rst |=> (|st.kw_latch))
        else $error("enabled key edge lost");
    take_mask_a: assert property (int_take |-> !$past(cpu_imask) && $past(cpu_insn_done))
        else $error("interrupt taken while masked or mid-instruction");
    vec_pri_a: assert property (ext_served_s |=> ext_vector_s)
        else $error("external source not served first");
    reset_vec_a: assert property (sys_reset |=> vector_addr == `RI_VEC_RESET && cpu_mask_set ##1 !int_take)
        else $error("reset vector or mask missing after reset");
    pod_len_a: assert property ($fell(pod_busy) |-> $past(sys_reset, 2))
        else $error("power-on delay ended without reset held");
endmodule // rstint_top

// file: testbench/rstint_cpu_model.sv
// cpu core model: instruction boundaries, stacking, mask bit and trap
module rstint_cpu_model (
    // clock and system reset
    input  wire logic        aclk,
    input  wire logic        sys_reset,
    // from the block
    input  wire logic        int_take,
    input  wire logic        cpu_mask_set,
    // bench commands
    input  wire logic        cli_req,
    input  wire logic        trap_req,
    // to the block
    output logic             cpu_imask,
    output logic             cpu_insn_done,
    output logic             cpu_stacked,
    output logic             soft_trap_instr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase = 2'h0;
    initial begin
        cpu_imask = 1'b1;
        cpu_insn_done = 1'b0;
        cpu_stacked = 1'b0;
        soft_trap_instr = 1'b0;
    end
    always @(posedge aclk) begin
        phase <= phase + 2'h1;
        // boundary every fourth cycle so a take never overlaps the next one
        cpu_insn_done <= (phase == 2'h3) && !sys_reset;
        cpu_stacked <= int_take;
        soft_trap_instr <= trap_req;
        if (sys_reset || cpu_mask_set) begin
            cpu_imask <= 1'b1;
        end else if (cli_req) begin
            cpu_imask <= 1'b0;
        end
    end
endmodule // rstint_cpu_model

// file: testbench/reset_and_interrupt_control_tb.sv
// self-checking bench of the reset and interrupt control block
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module reset_and_interrupt_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int POD = 20;
    logic aclk = 1'b0, aresetn = 1'b0, ext_reset_pin_n = 1'b1, watchdog_timeout_reset = 1'b0;
    logic watchdog_enable = 1'b0, mode_strap = 1'b1, ext_int_pin_n = 1'b1, cli_req = 1'b0, trap_req = 1'b0;
    logic [3:0] key_wake_pins_n = 4'hf, per_req = 4'h0, s_axi_wstrb = 4'hf;
    logic sys_reset, op_mode, cpu_imask, cpu_insn_done, cpu_stacked, soft_trap_instr, int_take;
    logic vector_valid, cpu_mask_set, ext_int_line;
    logic [12:0] vector_addr;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_fail = 0, tests_run = 0, n_take = 0, k0;
    always #25 aclk = ~aclk;
    always @(posedge aclk) if (int_take === 1'b1) n_take++;
    rstint_top #(.POD_CYCLES(15'h14)) rstint_top_i (.aclk, .aresetn, .ext_reset_pin_n, .watchdog_timeout_reset,
        .watchdog_enable, .mode_strap, .sys_reset, .op_mode, .ext_int_pin_n, .key_wake_pins_n,
        .pulse_width_int(per_req[0]), .event_count_int(per_req[1]), .serial_periph_int(per_req[2]),
        .timebase_int(per_req[3]), .cpu_imask, .cpu_insn_done, .cpu_stacked, .soft_trap_instr, .int_take,
        .vector_addr, .vector_valid, .cpu_mask_set, .ext_int_line, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rstint_cpu_model rstint_cpu_model_i (.aclk, .sys_reset, .int_take, .cpu_mask_set, .cli_req, .trap_req,
        .cpu_imask, .cpu_insn_done, .cpu_stacked, .soft_trap_instr);
    task automatic give_verdict();
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic hang();
        n_fail++;
        $display("CHECK FAILED wait exp answer got none");
        give_verdict();
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int k;
        bit aw, w;
        k = 0;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin aw = 1; s_axi_awvalid <= 1'b0; end
            if (s_axi_wvalid && s_axi_wready) begin w = 1; s_axi_wvalid <= 1'b0; end
            if (++k > 50) hang();
        end
        s_axi_bready <= 1'b1;
        do begin @(posedge aclk); if (++k > 99) hang(); end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        k = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin @(posedge aclk); if (++k > 50) hang(); end while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do begin @(posedge aclk); if (++k > 99) hang(); end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
    endtask
    // cli 1 lets the model clear its mask, cli 0 issues a soft trap instead
    task automatic vec(input bit cli, input logic [12:0] v);
        int k;
        k = 0;
        if (cli) cli_req <= 1'b1; else trap_req <= 1'b1;
        @(posedge aclk);
        cli_req <= 1'b0;
        trap_req <= 1'b0;
        do begin @(posedge aclk); if (++k > 40) hang(); end while (vector_valid !== 1'b1);
        `CHK("vector", v, vector_addr)
    endtask
    task automatic until_rst(input logic v);
        k0 = 0;
        do begin @(posedge aclk); if (++k0 > 60) hang(); end while (sys_reset !== v);
    endtask
    initial begin
        clk(2);
        aresetn <= 1'b1;
        clk(1);
        `CHK("reset vector", 13'h1ffe, vector_addr)
        `CHK("reset mask", 1'b1, cpu_mask_set)
        until_rst(1'b0);
        `CHK("delay length", 1'b1, k0 >= POD - 2 && k0 <= POD + 2)
        `CHK("mode after delay", 1'b0, op_mode)
        rd(8'h20, 32'h0, 2'h0);
        rd(8'h24, 32'h0, 2'h0);
        rd(8'h3c, 32'h0, 2'h2);
        wr(8'h3c, 8'hff, 2'h2);
        wr(8'h20, 8'hff, 2'h0);
        rd(8'h20, 32'h98, 2'h0);
        wr(8'h24, 8'hff, 2'h0);
        rd(8'h24, 32'h0, 2'h0);
        wr(8'h20, 8'h80, 2'h0);
        ext_int_pin_n <= 1'b0;
        clk(8);
        `CHK("line level", 1'b0, ext_int_line)
        wr(8'h24, 8'h08, 2'h0);
        rd(8'h24, 32'h80, 2'h0);
        wr(8'h20, 8'h88, 2'h0);
        ext_int_pin_n <= 1'b1;
        clk(8);
        wr(8'h24, 8'h08, 2'h0);
        rd(8'h24, 32'h0, 2'h0);
        ext_int_pin_n <= 1'b0;
        clk(8);
        rd(8'h24, 32'h80, 2'h0);
        k0 = n_take;
        clk(12);
        `CHK("masked take", k0, n_take)
        vec(1, 13'h1ffa);
        ext_int_pin_n <= 1'b1;
        wr(8'h24, 8'h08, 2'h0);
        wr(8'h28, 8'h02, 2'h0);
        wr(8'h20, 8'h10, 2'h0);
        key_wake_pins_n <= 4'he;
        clk(8);
        rd(8'h24, 32'h0, 2'h0);
        key_wake_pins_n <= 4'hc;
        clk(8);
        rd(8'h24, 32'h10, 2'h0);
        vec(1, 13'h1ff8);
        key_wake_pins_n <= 4'hf;
        wr(8'h24, 8'h01, 2'h0);
        rd(8'h24, 32'h0, 2'h0);
        per_req <= 4'hf;
        for (int i = 0; i < 4; i++) begin
            vec(1, 13'h1ff6 - 13'(2 * i));
            per_req[i] <= 1'b0;
        end
        vec(0, 13'h1ffc);
        watchdog_timeout_reset <= 1'b1;
        clk(6);
        `CHK("disabled watchdog", 1'b0, sys_reset)
        watchdog_enable <= 1'b1;
        ext_reset_pin_n <= 1'b0;
        clk(8);
        `CHK("reset on", 1'b1, sys_reset)
        watchdog_timeout_reset <= 1'b0;
        clk(8);
        `CHK("reset outlasts", 1'b1, sys_reset)
        `CHK("mode at watchdog end", 1'b1, op_mode)
        mode_strap <= 1'b0;
        ext_reset_pin_n <= 1'b1;
        until_rst(1'b0);
        `CHK("mode relatched", 1'b0, op_mode)
        rd(8'h20, 32'h0, 2'h0);
        rd(8'h28, 32'h0, 2'h0);
        give_verdict();
    end
endmodule // reset_and_interrupt_control_tb
